// ===== cfm_flag_mask.sv
/*
  flag and mask register group of a charger: four clear-on-read flag
  registers, four read/write mask registers and an interrupt request.
  assumes the serial front end delivers one-cycle read and write strobes
  with address and data synchronous to clk, and that condition detectors
  deliver one-cycle event pulses.
*/
`timescale 1ns/10ps
`include "cfm_regs.svh"

// ==========================================
// one clear-on-read flag register
module cfm_rc_flag #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] VALID = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // events and read strobe
  input wire logic [WIDTH-1:0] set_in,
  input wire logic clr,
  // state
  output logic [WIDTH-1:0] flag_q,
  output logic [WIDTH-1:0] new_set
);
  logic [WIDTH-1:0] flag_reg;
  logic [WIDTH-1:0] flag_next;

  // set wins over the read clear so no event is lost
  always_comb begin
    flag_next = ((clr ? '0 : flag_reg) | set_in) & VALID;
    new_set = set_in & VALID & (~flag_reg | {WIDTH{clr}});
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_q = flag_reg;
endmodule : cfm_rc_flag

// ==========================================
// top of the register group
module cfm_flag_mask
  import cfm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register access from the serial front end
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // charge-status events, bit 6 down to 0
  input wire logic [6:0] charge_status_event,
  // fault and temperature-region events, bit 6 unused
  input wire logic [7:0] fault_event,
  // thermistor and timer events
  input wire logic thermistor_open_event,
  input wire logic watchdog_expired_event,
  input wire logic safety_timer_expired_event,
  input wire logic regulator_overcurrent_event,
  input wire logic button_wake_one_event,
  input wire logic button_wake_two_event,
  input wire logic button_reset_warning_event,
  // power-up condition levels
  input wire logic input_power_good,
  input wire logic battery_below_uvlo,
  // interrupt request toward the host
  output logic irq_pulse
);
  // ==========================================
  // flag registers
  logic [7:0] cs_set;
  logic [7:0] timer_set;
  logic [7:0] therm_set;
  logic [7:0] cs_flags;
  logic [7:0] fault_flags;
  logic [7:0] therm_flags;
  logic [7:0] timer_flags;
  logic [7:0] cs_new;
  logic [7:0] fault_new;
  logic [7:0] therm_new;
  logic [7:0] timer_new;
  logic rd_cs;
  logic rd_fault;
  logic rd_therm;
  logic rd_timer;

  always_comb begin
    cs_set = {1'b0, charge_status_event};
    therm_set = 8'h00;
    therm_set[`CFM_BIT_THERMISTOR_OPEN] = thermistor_open_event;
    timer_set = 8'h00;
    timer_set[`CFM_BIT_WATCHDOG] = watchdog_expired_event;
    timer_set[`CFM_BIT_SAFETY_TIMER] = safety_timer_expired_event;
    timer_set[`CFM_BIT_REG_OVERCURRENT] = regulator_overcurrent_event;
    timer_set[`CFM_BIT_WAKE_ONE] = button_wake_one_event;
    timer_set[`CFM_BIT_WAKE_TWO] = button_wake_two_event;
    timer_set[`CFM_BIT_RESET_WARN] = button_reset_warning_event;
    rd_cs = reg_rd && (reg_addr == `CFM_ADDR_CS_FLAGS);
    rd_fault = reg_rd && (reg_addr == `CFM_ADDR_FAULT_FLAGS);
    rd_therm = reg_rd && (reg_addr == `CFM_ADDR_THERM_FLAGS);
    rd_timer = reg_rd && (reg_addr == `CFM_ADDR_TIMER_FLAGS);
  end

  cfm_rc_flag #(.WIDTH(8), .VALID(`CFM_CS_VALID)) u_cs_flags (
    .clk(clk),
    .nrst(nrst),
    .set_in(cs_set),
    .clr(rd_cs),
    .flag_q(cs_flags),
    .new_set(cs_new)
  );

  // reserved bit 6 never sets
  cfm_rc_flag #(.WIDTH(8), .VALID(`CFM_FAULT_VALID)) u_fault_flags (
    .clk(clk),
    .nrst(nrst),
    .set_in(fault_event),
    .clr(rd_fault),
    .flag_q(fault_flags),
    .new_set(fault_new)
  );

  cfm_rc_flag #(.WIDTH(8), .VALID(`CFM_THERM_VALID)) u_therm_flags (
    .clk(clk),
    .nrst(nrst),
    .set_in(therm_set),
    .clr(rd_therm),
    .flag_q(therm_flags),
    .new_set(therm_new)
  );

  cfm_rc_flag #(.WIDTH(8), .VALID(`CFM_TIMER_VALID)) u_timer_flags (
    .clk(clk),
    .nrst(nrst),
    .set_in(timer_set),
    .clr(rd_timer),
    .flag_q(timer_flags),
    .new_set(timer_new)
  );

  // ==========================================
  // mask registers
  logic [7:0] cs_mask_reg;
  logic [7:0] cs_mask_next;
  logic [7:0] fault_mask_reg;
  logic [7:0] fault_mask_next;
  logic [3:0] therm_mask_reg;
  logic [3:0] therm_mask_next;
  logic [7:0] timer_mask_reg;
  logic [7:0] timer_mask_next;

  always_comb begin
    cs_mask_next = cs_mask_reg;
    fault_mask_next = fault_mask_reg;
    therm_mask_next = therm_mask_reg;
    timer_mask_next = timer_mask_reg;
    if (reg_wr && (reg_addr == `CFM_ADDR_CS_MASK)) begin
      cs_mask_next = reg_wdata;
    end else if (reg_wr && (reg_addr == `CFM_ADDR_FAULT_MASK)) begin
      fault_mask_next = reg_wdata;
    end else if (reg_wr && (reg_addr == `CFM_ADDR_THERM_MASK)) begin
      therm_mask_next = reg_wdata[3:0];
    end else if (reg_wr && (reg_addr == `CFM_ADDR_TIMER_MASK)) begin
      timer_mask_next = reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs_mask_reg <= `CFM_CS_MASK_RESET;
      fault_mask_reg <= `CFM_FAULT_MASK_RESET;
      therm_mask_reg <= `CFM_THERM_MASK_RESET;
      timer_mask_reg <= `CFM_TIMER_MASK_RESET;
    end else begin
      cs_mask_reg <= cs_mask_next;
      fault_mask_reg <= fault_mask_next;
      therm_mask_reg <= therm_mask_next;
      timer_mask_reg <= timer_mask_next;
    end
  end

  // ==========================================
  // power-up power-good suppression
  cfm_state_t state_reg;
  cfm_state_t state_next;
  logic pg_quiet_reg;
  logic pg_quiet_next;

  // levels are caught by a clocked step after reset release, not by reset
  always_comb begin
    state_next = state_reg;
    pg_quiet_next = pg_quiet_reg;
    case (state_reg)
      CFM_ST_STARTUP: begin
        pg_quiet_next = input_power_good && battery_below_uvlo;
        state_next = CFM_ST_RUN;
      end
      CFM_ST_RUN: begin
        if (rd_cs) begin
          pg_quiet_next = 1'b0;
        end
      end
      default: begin
        state_next = CFM_ST_STARTUP;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= CFM_ST_STARTUP;
      pg_quiet_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pg_quiet_reg <= pg_quiet_next;
    end
  end

  // ==========================================
  // interrupt request and read data
  logic [7:0] cs_gate;
  logic irq_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_comb begin
    cs_gate = ~cs_mask_reg;
    // startup window and the quiet flag both hold off the power-good request
    if (pg_quiet_next || (state_reg == CFM_ST_STARTUP)) begin
      cs_gate[`CFM_BIT_POWER_GOOD] = 1'b0;
    end
    irq_next = |(cs_new & cs_gate)
      | |(fault_new & ~fault_mask_reg)
      | |(therm_new[0] & ~therm_mask_reg[0])
      | |(timer_new & ~timer_mask_reg);
    rdata_next = rdata_reg;
    if (reg_rd) begin
      if (reg_addr == `CFM_ADDR_CS_FLAGS) begin
        rdata_next = cs_flags;
      end else if (reg_addr == `CFM_ADDR_FAULT_FLAGS) begin
        rdata_next = fault_flags;
      end else if (reg_addr == `CFM_ADDR_THERM_FLAGS) begin
        rdata_next = therm_flags;
      end else if (reg_addr == `CFM_ADDR_TIMER_FLAGS) begin
        rdata_next = timer_flags;
      end else if (reg_addr == `CFM_ADDR_CS_MASK) begin
        rdata_next = cs_mask_reg;
      end else if (reg_addr == `CFM_ADDR_FAULT_MASK) begin
        rdata_next = fault_mask_reg;
      end else if (reg_addr == `CFM_ADDR_THERM_MASK) begin
        rdata_next = {`CFM_THERM_MASK_TOP, therm_mask_reg};
      end else if (reg_addr == `CFM_ADDR_TIMER_MASK) begin
        rdata_next = timer_mask_reg;
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_pulse <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      irq_pulse <= irq_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
endmodule : cfm_flag_mask

// ===== cfm_regs.svh
/*
  register offsets, field positions, reset values and valid-bit masks
  of the charger flag and mask register group.
  assumes it is included by bare name from the package and the design.
*/
`ifndef CFM_REGS_SVH
`define CFM_REGS_SVH

// ==========================================
// offsets
`define CFM_ADDR_CS_FLAGS 8'h03
`define CFM_ADDR_FAULT_FLAGS 8'h04
`define CFM_ADDR_THERM_FLAGS 8'h05
`define CFM_ADDR_TIMER_FLAGS 8'h06
`define CFM_ADDR_CS_MASK 8'h07
`define CFM_ADDR_FAULT_MASK 8'h08
`define CFM_ADDR_THERM_MASK 8'h09
`define CFM_ADDR_TIMER_MASK 8'h0a

// ==========================================
// implemented bits of each flag register
`define CFM_CS_VALID 8'h7f
`define CFM_FAULT_VALID 8'hbf
`define CFM_THERM_VALID 8'h01
`define CFM_TIMER_VALID 8'h77

// ==========================================
// reset values
`define CFM_FLAG_RESET 8'h00
`define CFM_CS_MASK_RESET 8'h00
`define CFM_FAULT_MASK_RESET 8'h00
`define CFM_THERM_MASK_RESET 4'h1
`define CFM_THERM_MASK_TOP 4'h7
`define CFM_TIMER_MASK_RESET 8'h00

// ==========================================
// field positions
`define CFM_BIT_THERMISTOR_OPEN 0
`define CFM_BIT_WATCHDOG 6
`define CFM_BIT_SAFETY_TIMER 5
`define CFM_BIT_REG_OVERCURRENT 4
`define CFM_BIT_WAKE_ONE 2
`define CFM_BIT_WAKE_TWO 1
`define CFM_BIT_RESET_WARN 0
`define CFM_BIT_POWER_GOOD 0

`endif

// ===== cfm_pkg.sv
/*
  types of the charger flag and mask register group.
  assumes cfm_regs.svh is on the include path.
*/
package cfm_pkg;
  `include "cfm_regs.svh"

  // ==========================================
  // power-up tracking for the power-good interrupt
  typedef enum logic [1:0] {
    CFM_ST_STARTUP = 2'b01,
    CFM_ST_RUN = 2'b10
  } cfm_state_t;
endpackage : cfm_pkg

// ===== cfm_flag_mask_assertions.sv
/*
  checker of the flag and mask group, bound to cfm_flag_mask.
  assumes strobe-port access and one-cycle event pulses.
*/
`timescale 1ns/10ps
// ==========================================
// checker
module cfm_checker (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // events and request
  input wire logic [6:0] charge_status_event,
  input wire logic [7:0] fault_event,
  input wire logic thermistor_open_event,
  input wire logic watchdog_expired_event,
  input wire logic safety_timer_expired_event,
  input wire logic regulator_overcurrent_event,
  input wire logic button_wake_one_event,
  input wire logic button_wake_two_event,
  input wire logic button_reset_warning_event,
  input wire logic irq_pulse
);
  logic any_ev;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // fault bit 6 is no source
  assign any_ev = |{charge_status_event, fault_event & 8'hbf, thermistor_open_event,
    watchdog_expired_event, safety_timer_expired_event, regulator_overcurrent_event,
    button_wake_one_event, button_wake_two_event, button_reset_warning_event};
  sequence s_rd(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  property p_set(logic ev, logic [7:0] a, int b);
    ev ##1 s_rd(a) |=> reg_rdata[b];
  endproperty
  a_therm_flag_set: assert property (p_set(thermistor_open_event, 8'h05, 0))
    else $error("thermistor flag not set");
  a_wd_flag_set: assert property (p_set(watchdog_expired_event, 8'h06, 6))
    else $error("watchdog flag not set");
  a_ovc_flag_set: assert property (p_set(regulator_overcurrent_event, 8'h06, 4))
    else $error("overcurrent flag not set");
  a_timer_reserved: assert property (s_rd(8'h06) |=> reg_rdata[7] == 1'b0 && !reg_rdata[3])
    else $error("reserved timer bit set");
  a_therm_reserved: assert property (s_rd(8'h05) |=> reg_rdata[7:1] == 7'h00)
    else $error("reserved thermistor bit set");
  a_timer_clear: assert property (reg_rd && reg_addr == 8'h06 && !any_ev ##1 !any_ev
    ##1 s_rd(8'h06) |=> reg_rdata == 8'h00)
    else $error("timer flags not cleared");
  a_mask_readback: assert property (reg_wr && reg_addr == 8'h07 ##2 s_rd(8'h07)
    |=> reg_rdata == $past(reg_wdata, 3))
    else $error("mask readback wrong");
  a_irq_cause: assert property (irq_pulse |-> $past(any_ev))
    else $error("request without event");
  a_irq_single: assert property (irq_pulse && !any_ev |=> !irq_pulse)
    else $error("request too long");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
endmodule : cfm_checker

bind cfm_flag_mask cfm_checker u_chk (.clk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
  .reg_rdata, .charge_status_event, .fault_event, .thermistor_open_event,
  .watchdog_expired_event, .safety_timer_expired_event, .regulator_overcurrent_event,
  .button_wake_one_event, .button_wake_two_event, .button_reset_warning_event, .irq_pulse);

// ===== cfm_host_model.sv
/*
  host model: register reads and writes on the strobe port.
  assumes one access at a time through its task.
*/
`timescale 1ns/10ps
// ==========================================
// host model
module cfm_host_model (
  // clock
  input wire logic clk,
  // register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // idle lines invert so a stale address never looks held
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
    input int gap, output logic [7:0] q);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1 q = reg_rdata;
  endtask : acc
endmodule : cfm_host_model

// ===== tb_top.sv
/*
  testbench of cfm_flag_mask: register access, events, request count.
  assumes the host model and bound checker are compiled first.
*/
`timescale 1ns/10ps
// ==========================================
// testbench
module tb_top;
  logic clk;
  logic nrst;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [6:0] cs_ev;
  logic [7:0] f_ev;
  logic [6:0] t_ev;
  logic pg;
  logic uv;
  logic irq_pulse;
  logic [7:0] n_irq = 8'h00;
  logic [7:0] e_irq;
  logic [7:0] q;
  logic [7:0] m;
  logic [31:0] seed;
  int gap;
  int n_mismatch;
  int compares;

  // t_ev bit 3 feeds the thermistor flag
  cfm_flag_mask uut (.clk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .charge_status_event(cs_ev), .fault_event(f_ev), .thermistor_open_event(t_ev[3]),
    .watchdog_expired_event(t_ev[6]), .safety_timer_expired_event(t_ev[5]),
    .regulator_overcurrent_event(t_ev[4]), .button_wake_one_event(t_ev[2]),
    .button_wake_two_event(t_ev[1]), .button_reset_warning_event(t_ev[0]),
    .input_power_good(pg), .battery_below_uvlo(uv), .irq_pulse);
  cfm_host_model host (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (irq_pulse === 1'b1) begin
      n_irq <= n_irq + 8'h01;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] timer_img(input logic [6:0] t);
    return {1'b0, t[6:4], 1'b0, t[2:0]};
  endfunction : timer_img
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_irq(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t irq count got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_irq
  task automatic ev(input logic [6:0] c, input logic [7:0] f, input logic [6:0] t);
    @(posedge clk);
    cs_ev <= c;
    f_ev <= f;
    t_ev <= t;
    @(posedge clk);
    cs_ev <= 7'h00;
    f_ev <= 8'h00;
    t_ev <= 7'h00;
    @(posedge clk);
    #1;
  endtask : ev
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.acc(1'b0, a, 8'h00, gap, q);
    chk(q, e);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.acc(1'b1, a, d, gap, q);
  endtask : wr
  task automatic summarize();
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  // ==========================================
  // sequence
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    nrst = 1'b0;
    pg = 1'b1;
    uv = 1'b1;
    cs_ev = 7'h00;
    f_ev = 8'h00;
    t_ev = 7'h00;
    seed = 32'h41a3ca8c;
    gap = 0;
    n_mismatch = 0;
    compares = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h71);
    @(posedge clk);
    pg <= 1'b0;
    uv <= 1'b0;
    ev(7'h01, 8'h00, 7'h00);
    chk_irq(n_irq, 8'h00);
    rd(8'h03, 8'h01);
    ev(7'h01, 8'h00, 7'h00);
    chk_irq(n_irq, 8'h01);
    wr(8'h07, 8'h40);
    wr(8'h08, 8'h80);
    ev(7'h60, 8'hc1, 7'h00);
    chk_irq(n_irq, 8'h02);
    // power-good flag from the second pulse is still unread
    rd(8'h03, 8'h61);
    rd(8'h04, 8'h81);
    // each mask bit alone against its own flag
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      wr(8'h07, m);
      wr(8'h08, m);
      ev(m[6:0], m & 8'hbf, 7'h00);
      chk_irq(n_irq, 8'h02);
      rd(8'h03, m & 8'h7f);
      rd(8'h04, m & 8'hbf);
    end
    e_irq = 8'h02;
    for (int k = 0; k < 40; k++) begin
      seed = lfsr(seed);
      gap = 0;
      wr(8'h07, seed[23:16]);
      rd(8'h07, seed[23:16]);
      gap = seed[9:8];
      ev(7'h00, 8'h00, seed[6:0]);
      if ((seed[6:0] & 7'h77) != 7'h00) begin
        e_irq = e_irq + 8'h01;
      end
      chk_irq(n_irq, e_irq);
      rd(8'h06, timer_img(seed[6:0]));
      rd(8'h05, {7'h00, seed[3]});
    end
    gap = 0;
    rd(8'h06, 8'h00);
    rd(8'h06, 8'h00);
    // ==========================================
    // mid-run reset, healthy battery: power-good request not held off
    @(posedge clk);
    nrst <= 1'b0;
    pg <= 1'b1;
    uv <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h07, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h71);
    rd(8'h06, 8'h00);
    ev(7'h01, 8'h00, 7'h00);
    e_irq = e_irq + 8'h01;
    chk_irq(n_irq, e_irq);
    rd(8'h03, 8'h01);
    // event and read of its register on back-to-back edges
    gap = 1;
    fork
      ev(7'h00, 8'h00, 7'h58);
      rd(8'h06, 8'h50);
    join
    e_irq = e_irq + 8'h01;
    chk_irq(n_irq, e_irq);
    fork
      ev(7'h00, 8'h00, 7'h08);
      rd(8'h05, 8'h01);
    join
    chk_irq(n_irq, e_irq);
    // unmasked thermistor path
    gap = 0;
    wr(8'h09, 8'h00);
    rd(8'h09, 8'h70);
    ev(7'h00, 8'h00, 7'h08);
    e_irq = e_irq + 8'h01;
    chk_irq(n_irq, e_irq);
    rd(8'h05, 8'h01);
    summarize();
  end
endmodule : tb_top
